// ==== hdl/bbse_core.sv ====
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// How it works
// [RULE1] Signed ge branch when N xor V clear
// [RULE2] Signed less branch when N xor V set
// [RULE3] Nonnegative branch when N clear
// [RULE4] Half-carry branches on H set or clear
// [RULE5] Transfer-flag branches on T set or clear
// [RULE6] Overflow branches on V set or clear
// [RULE7] Interrupt-state branches on I set or clear
// [RULE8] I/O bit set/clear, two cycles, flags untouched
// [RULE9] Left shift, zero into bit 0
// [RULE10] Right shift, zero into bit 7
// [RULE11] Rotate left through carry
// [RULE12] Rotate right through carry
// [RULE13] Arithmetic right shift keeps bit 7
// [RULE14] Bit store copies register bit into T
// [RULE15] Bit load copies T into register bit
// [RULE16] Each flag set or cleared alone
// [RULE17] Load from X then X plus one
// [RULE18] Untaken branch one cycle, taken two, signed
module bbse_core
    import bbse_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic branch_cond(input bbse_op_t op, input logic [7:0] f);
        case (op)
            OP_BR_NONNEG: branch_cond = !f[FLAG_N]; // RULE3
            OP_BR_SGE: branch_cond = !(f[FLAG_N] ^ f[FLAG_V]); // RULE1
            OP_BR_SLT: branch_cond = f[FLAG_N] ^ f[FLAG_V]; // RULE2
            OP_BR_HSET: branch_cond = f[FLAG_H]; // RULE4
            OP_BR_HCLR: branch_cond = !f[FLAG_H]; // RULE4
            OP_BR_TSET: branch_cond = f[FLAG_T]; // RULE5
            OP_BR_TCLR: branch_cond = !f[FLAG_T]; // RULE5
            OP_BR_VSET: branch_cond = f[FLAG_V]; // RULE6
            OP_BR_VCLR: branch_cond = !f[FLAG_V]; // RULE6
            OP_BR_IEN: branch_cond = f[FLAG_I]; // RULE7
            OP_BR_IDIS: branch_cond = !f[FLAG_I]; // RULE7
            default: branch_cond = 1'b0;
        endcase
    endfunction

    function automatic logic is_branch(input bbse_op_t op);
        is_branch = (op >= OP_BR_NONNEG) && (op <= OP_BR_IDIS);
    endfunction

    // ****************************************
    // State
    // ****************************************
    bbse_state_t state_reg;
    logic [31:0] cmd_reg;
    logic [7:0] flags_reg;
    logic [15:0] pc_reg;
    logic [15:0] xptr_reg;
    logic [7:0] tmp_reg;
    logic [1:0] last_cycles_reg;
    logic last_taken_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg;
    logic wstrb1_reg;
    logic aw_have_reg;
    logic w_have_reg;

    bbse_op_t op;
    logic [4:0] rd_idx;
    logic [2:0] bit_idx;
    logic [15:0] pc_target;
    logic cond;
    logic exec;
    logic second;
    assign op = bbse_op_t'(cmd_reg[CMD_OP_LSB +: 5]);
    assign rd_idx = cmd_reg[CMD_REG_LSB +: 5];
    assign bit_idx = cmd_reg[CMD_BIT_LSB +: 3];
    assign exec = (state_reg == S_EXEC);
    assign second = (state_reg == S_SECOND);
    assign cond = branch_cond(op, flags_reg);
    // Offset is signed two's complement, sign extended to the counter width
    assign pc_target = pc_reg + 16'h0001
        + {{(16-OFFSET_W){cmd_reg[CMD_ARG_LSB+OFFSET_W-1]}},
           cmd_reg[CMD_ARG_LSB +: OFFSET_W]}; // RULE18

    // ****************************************
    // Bus write decode
    // ****************************************
    logic wr_do;
    logic ar_hs;
    assign wr_do = aw_have_reg && w_have_reg && !s_axi_bvalid && exec == 1'b0 && !second;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    logic wr_gpr;
    logic wr_io;
    logic wr_dmem;
    logic wr_ctl;
    assign wr_gpr = wr_do && wstrb0_reg && (awaddr_reg[9:7] == REGION_GPR);
    assign wr_io = wr_do && wstrb0_reg && (awaddr_reg[9:8] == REGION_IO);
    assign wr_dmem = wr_do && wstrb0_reg && (awaddr_reg[9:8] == REGION_DMEM);
    assign wr_ctl = wr_do && (awaddr_reg[9:7] == REGION_CTL);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] gpr_src;
    logic [7:0] gpr_bus;
    logic [7:0] io_src;
    logic [7:0] io_bus;
    logic [7:0] dm_src;
    logic [7:0] dm_bus;
    logic [7:0] sh_res;
    logic sh_c;
    logic sh_z;
    logic sh_n;
    logic sh_v;
    logic gpr_we;
    logic [4:0] gpr_waddr;
    logic [7:0] gpr_wdata;
    logic shift_op;
    assign shift_op = (op >= OP_LSL && op <= OP_ASR) || op == OP_BLD;

    always_comb
    begin
        gpr_we = wr_gpr;
        gpr_waddr = awaddr_reg[6:2];
        gpr_wdata = wdata_reg[7:0];
        if (exec && shift_op)
        begin
            gpr_we = 1'b1; // RULE9 RULE10 RULE11 RULE12 RULE13 RULE15
            gpr_waddr = rd_idx;
            gpr_wdata = sh_res;
        end
        else if (second && op == OP_LD_XINC)
        begin
            gpr_we = 1'b1; // RULE17
            gpr_waddr = rd_idx;
            gpr_wdata = tmp_reg;
        end
    end

    bbse_ram #(.DEPTH(32), .AW(5)) u_gpr (
        .clk(clk), .wr_en(gpr_we), .wr_addr(gpr_waddr), .wr_data(gpr_wdata),
        .rd_addr_a(rd_idx), .rd_data_a(gpr_src),
        .rd_addr_b(s_axi_araddr[6:2]), .rd_data_b(gpr_bus)
    );

    // I/O bits change by read-modify-write over the two cycles
    logic io_we;
    logic [7:0] io_wdata;
    logic [7:0] io_mod;
    always_comb
    begin
        io_mod = tmp_reg;
        io_mod[bit_idx] = (op == OP_IO_SET); // RULE8
    end
    assign io_we = wr_io || (second && (op == OP_IO_SET || op == OP_IO_CLR));
    assign io_wdata = wr_io ? wdata_reg[7:0] : io_mod;

    bbse_ram #(.DEPTH(64), .AW(6)) u_io (
        .clk(clk), .wr_en(io_we),
        .wr_addr(wr_io ? awaddr_reg[7:2] : cmd_reg[CMD_ARG_LSB +: 6]),
        .wr_data(io_wdata),
        .rd_addr_a(cmd_reg[CMD_ARG_LSB +: 6]), .rd_data_a(io_src),
        .rd_addr_b(s_axi_araddr[7:2]), .rd_data_b(io_bus)
    );

    bbse_ram #(.DEPTH(64), .AW(6)) u_dmem (
        .clk(clk), .wr_en(wr_dmem), .wr_addr(awaddr_reg[7:2]),
        .wr_data(wdata_reg[7:0]),
        .rd_addr_a(xptr_reg[5:0]), .rd_data_a(dm_src),
        .rd_addr_b(s_axi_araddr[7:2]), .rd_data_b(dm_bus)
    );

    bbse_shift u_shift (
        .op(op), .src(gpr_src), .carry_in(flags_reg[FLAG_C]), .tflag(flags_reg[FLAG_T]),
        .bit_sel(bit_idx), .res(sh_res), .c_out(sh_c), .z_out(sh_z), .n_out(sh_n),
        .v_out(sh_v)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= S_IDLE;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                begin
                    if (wr_ctl && awaddr_reg == OFS_CMD && wstrb0_reg)
                    begin
                        state_reg <= S_EXEC;
                    end
                end
                S_EXEC:
                begin
                    if ((is_branch(op) && cond) || op == OP_IO_SET || op == OP_IO_CLR
                        || op == OP_LD_XINC)
                    begin
                        state_reg <= S_SECOND; // RULE8 RULE18
                    end
                    else
                    begin
                        state_reg <= S_IDLE; // RULE18
                    end
                end
                S_SECOND: state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_reg <= 32'h0000_0000;
            tmp_reg <= 8'h00;
            last_cycles_reg <= 2'h0;
            last_taken_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctl && awaddr_reg == OFS_CMD && wstrb0_reg)
            begin
                cmd_reg <= wdata_reg;
            end
            if (exec)
            begin
                tmp_reg <= (op == OP_LD_XINC) ? dm_src : io_src;
                last_taken_reg <= is_branch(op) && cond;
                last_cycles_reg <= CYC_SHORT;
            end
            if (second)
            begin
                last_cycles_reg <= CYC_LONG;
            end
        end
    end

    // Program counter moves by one, or by offset plus one when taken
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pc_reg <= PC_RST;
        end
        else if (wr_ctl && awaddr_reg == OFS_PC)
        begin
            if (wstrb0_reg)
            begin
                pc_reg[7:0] <= wdata_reg[7:0];
            end
            if (wstrb1_reg)
            begin
                pc_reg[15:8] <= wdata_reg[15:8];
            end
        end
        else if (exec && !(is_branch(op) && cond) && state_reg != S_SECOND)
        begin
            if (op != OP_IO_SET && op != OP_IO_CLR && op != OP_LD_XINC)
            begin
                pc_reg <= pc_reg + 16'h0001; // RULE18
            end
        end
        else if (second)
        begin
            pc_reg <= is_branch(op) ? pc_target : pc_reg + 16'h0001; // RULE18
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            xptr_reg <= XPTR_RST;
        end
        else if (wr_ctl && awaddr_reg == OFS_XPTR)
        begin
            if (wstrb0_reg)
            begin
                xptr_reg[7:0] <= wdata_reg[7:0];
            end
            if (wstrb1_reg)
            begin
                xptr_reg[15:8] <= wdata_reg[15:8];
            end
        end
        else if (second && op == OP_LD_XINC)
        begin
            xptr_reg <= xptr_reg + 16'h0001; // RULE17
        end
    end

    // Shifts leave the signed test flag alone: only Z, C, N, V move
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_reg <= FLAGS_RST;
        end
        else if (wr_ctl && awaddr_reg == OFS_FLAGS && wstrb0_reg)
        begin
            flags_reg <= wdata_reg[7:0];
        end
        else if (exec)
        begin
            if (op >= OP_LSL && op <= OP_ASR)
            begin
                flags_reg[FLAG_C] <= sh_c; // RULE9 RULE10 RULE11 RULE12 RULE13
                flags_reg[FLAG_Z] <= sh_z;
                flags_reg[FLAG_N] <= sh_n;
                flags_reg[FLAG_V] <= sh_v;
            end
            else if (op == OP_BST)
            begin
                flags_reg[FLAG_T] <= gpr_src[bit_idx]; // RULE14
            end
            else if (op == OP_FLAG_SET || op == OP_FLAG_CLR)
            begin
                flags_reg[cmd_reg[CMD_ARG_LSB +: 3]] <= (op == OP_FLAG_SET); // RULE16
            end
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            wstrb1_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_reg <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
                wstrb1_reg <= s_axi_wstrb[1];
                w_have_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_do)
            begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Status is read-only; a gap in the control block is unmapped
                s_axi_bresp <= (awaddr_reg[9:7] == REGION_CTL
                    && (awaddr_reg == OFS_STATUS || awaddr_reg > OFS_XPTR))
                    || awaddr_reg[9:8] == 2'h3 ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr[9:7] == REGION_GPR)
            begin
                s_axi_rdata[7:0] <= gpr_bus;
            end
            else if (s_axi_araddr[9:8] == REGION_IO)
            begin
                s_axi_rdata[7:0] <= io_bus;
            end
            else if (s_axi_araddr[9:8] == REGION_DMEM)
            begin
                s_axi_rdata[7:0] <= dm_bus;
            end
            else
            begin
                case (s_axi_araddr)
                    OFS_CMD: s_axi_rdata <= cmd_reg;
                    OFS_STATUS: s_axi_rdata[3:0] <= {last_cycles_reg, last_taken_reg,
                                                     state_reg != S_IDLE};
                    OFS_FLAGS: s_axi_rdata[7:0] <= flags_reg;
                    OFS_PC: s_axi_rdata[15:0] <= pc_reg;
                    OFS_XPTR: s_axi_rdata[15:0] <= xptr_reg;
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_branch_untaken_one: assert property (exec && is_branch(op) && !cond // RULE18
        |=> state_reg == S_IDLE && pc_reg == $past(pc_reg) + 16'h0001)
        else $error("untaken branch not one cycle");
    a_branch_taken_pc: assert property (exec && is_branch(op) && cond // RULE18
        |=> second ##1 state_reg == S_IDLE && pc_reg == $past(pc_target, 2))
        else $error("taken branch target wrong");
    a_signed_ge_take: assert property (exec && op == OP_BR_SGE // RULE1
        && (flags_reg[FLAG_N] == flags_reg[FLAG_V]) |=> second)
        else $error("signed ge not taken");
    a_signed_lt_take: assert property (exec && op == OP_BR_SLT // RULE2
        && (flags_reg[FLAG_N] != flags_reg[FLAG_V]) |=> second)
        else $error("signed less not taken");
    a_io_flags_keep: assert property (exec && (op == OP_IO_SET || op == OP_IO_CLR) // RULE8
        |=> second && $stable(flags_reg) ##1 state_reg == S_IDLE && $stable(flags_reg))
        else $error("io bit op timing or flags wrong");
    a_lsl_carry_out: assert property (exec && op == OP_LSL // RULE9
        |-> gpr_wdata == {gpr_src[6:0], 1'b0} ##1 flags_reg[FLAG_C] == $past(gpr_src[7]))
        else $error("left shift wrong");
    a_rol_carry_in: assert property (exec && op == OP_ROL // RULE11
        |-> gpr_wdata[0] == flags_reg[FLAG_C] ##1 flags_reg[FLAG_C] == $past(gpr_src[7]))
        else $error("rotate left wrong");
    a_bst_t_only: assert property (exec && op == OP_BST // RULE14
        |=> flags_reg[FLAG_T] == $past(gpr_src[bit_idx])
        && (flags_reg & 8'hbf) == ($past(flags_reg) & 8'hbf))
        else $error("bit store wrong");
    a_ld_post_inc: assert property (exec && op == OP_LD_XINC // RULE17
        |=> $stable(flags_reg) ##1 xptr_reg == $past(xptr_reg, 2) + 16'h0001)
        else $error("post increment wrong");

    c_branch_taken: cover property (exec && is_branch(op) && cond ##1 second);
    c_io_set: cover property (exec && op == OP_IO_SET ##2 state_reg == S_IDLE);
    c_load_inc: cover property (second && op == OP_LD_XINC);
endmodule // bbse_core

// ==== hdl/bbse_pkg.sv ====
package bbse_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 10;
    localparam logic [9:0] OFS_CMD = 10'h000;
    localparam logic [9:0] OFS_STATUS = 10'h004;
    localparam logic [9:0] OFS_FLAGS = 10'h008;
    localparam logic [9:0] OFS_PC = 10'h00c;
    localparam logic [9:0] OFS_XPTR = 10'h010;
    localparam logic [2:0] REGION_CTL = 3'h0;
    localparam logic [2:0] REGION_GPR = 3'h1;
    localparam logic [1:0] REGION_IO = 2'h1;
    localparam logic [1:0] REGION_DMEM = 2'h2;

    // ****************************************
    // Command word fields
    // ****************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_REG_LSB = 8;
    localparam int CMD_BIT_LSB = 13;
    localparam int CMD_ARG_LSB = 16;
    localparam int OFFSET_W = 7;

    // ****************************************
    // Status flag positions and reset values
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] XPTR_RST = 16'h0000;

    // ****************************************
    // Timing and bus answers
    // ****************************************
    localparam logic [1:0] CYC_SHORT = 2'h1;
    localparam logic [1:0] CYC_LONG = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_BR_NONNEG = 5'h01,
        OP_BR_SGE = 5'h02,
        OP_BR_SLT = 5'h03,
        OP_BR_HSET = 5'h04,
        OP_BR_HCLR = 5'h05,
        OP_BR_TSET = 5'h06,
        OP_BR_TCLR = 5'h07,
        OP_BR_VSET = 5'h08,
        OP_BR_VCLR = 5'h09,
        OP_BR_IEN = 5'h0a,
        OP_BR_IDIS = 5'h0b,
        OP_IO_SET = 5'h0c,
        OP_IO_CLR = 5'h0d,
        OP_LSL = 5'h0e,
        OP_LSR = 5'h0f,
        OP_ROL = 5'h10,
        OP_ROR = 5'h11,
        OP_ASR = 5'h12,
        OP_BST = 5'h13,
        OP_BLD = 5'h14,
        OP_FLAG_SET = 5'h15,
        OP_FLAG_CLR = 5'h16,
        OP_LD_XINC = 5'h17
    } bbse_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_EXEC = 3'b010,
        S_SECOND = 3'b100
    } bbse_state_t;

endpackage

// ==== hdl/bbse_ram.sv ====
`timescale 1ns/100ps
// Byte array with one write port and two combinational read ports
module bbse_ram #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read ports
    input wire logic [AW-1:0] rd_addr_a,
    output logic [7:0] rd_data_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [7:0] rd_data_b
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
endmodule // bbse_ram

// ==== hdl/bbse_shift.sv ====
`timescale 1ns/100ps
// Shift, rotate and bit-load datapath with its flag results
module bbse_shift
    import bbse_pkg::*;
(
    // Operation
    input wire bbse_op_t op,
    input wire logic [7:0] src,
    input wire logic carry_in,
    input wire logic tflag,
    input wire logic [2:0] bit_sel,
    // Results
    output logic [7:0] res,
    output logic c_out,
    output logic z_out,
    output logic n_out,
    output logic v_out
);
    always_comb
    begin
        res = src;
        c_out = carry_in;
        case (op)
            OP_LSL:
            begin
                res = {src[6:0], 1'b0};
                c_out = src[7];
            end
            OP_LSR:
            begin
                res = {1'b0, src[7:1]};
                c_out = src[0];
            end
            OP_ROL:
            begin
                res = {src[6:0], carry_in};
                c_out = src[7];
            end
            OP_ROR:
            begin
                res = {carry_in, src[7:1]};
                c_out = src[0];
            end
            OP_ASR:
            begin
                res = {src[7], src[7:1]};
                c_out = src[0];
            end
            OP_BLD:
            begin
                res[bit_sel] = tflag;
            end
            default:
            begin
                res = src;
                c_out = carry_in;
            end
        endcase
        z_out = (res == 8'h00);
        n_out = res[7];
        // Overflow after a shift is result sign (bit 7) xor carry out
        v_out = res[7] ^ c_out;
    end
endmodule // bbse_shift

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench
    import bbse_pkg::*;
;
    typedef struct packed {logic [31:0] c; logic [7:0] f, s, r, e; logic [15:0] p;
        logic [1:0] y;} bbse_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] s_axi_awaddr = 10'h000;
    logic [9:0] s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d, s;
    int n_mismatch = 0;
    int tests_run = 0;
    bbse_row_t rows[18] = '{
        '{32'h00050102, 8'h0c, 8'h00, 8'h00, 8'h0c, 16'h0016, 2'h2},
        '{32'h007d0103, 8'h04, 8'h00, 8'h00, 8'h04, 16'h000e, 2'h2},
        '{32'h00050101, 8'h04, 8'h00, 8'h00, 8'h04, 16'h0011, 2'h1},
        '{32'h00050104, 8'h20, 8'h00, 8'h00, 8'h20, 16'h0016, 2'h2},
        '{32'h00050107, 8'h40, 8'h00, 8'h00, 8'h40, 16'h0011, 2'h1},
        '{32'h00050108, 8'h08, 8'h00, 8'h00, 8'h08, 16'h0016, 2'h2},
        '{32'h0005010b, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0016, 2'h2},
        '{32'h00050105, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0016, 2'h2},
        '{32'h00050106, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0011, 2'h1},
        '{32'h00050109, 8'h08, 8'h00, 8'h00, 8'h08, 16'h0011, 2'h1},
        '{32'h0005010a, 8'h80, 8'h00, 8'h00, 8'h80, 16'h0016, 2'h2},
        '{32'h0000010e, 8'h00, 8'h81, 8'h02, 8'h09, 16'h0011, 2'h1},
        '{32'h0000010f, 8'h00, 8'h01, 8'h00, 8'h0b, 16'h0011, 2'h1},
        '{32'h00000110, 8'h01, 8'h80, 8'h01, 8'h09, 16'h0011, 2'h1},
        '{32'h00000111, 8'h01, 8'h01, 8'h80, 8'h05, 16'h0011, 2'h1},
        '{32'h00000112, 8'h00, 8'h80, 8'hc0, 8'h0c, 16'h0011, 2'h1},
        '{32'h0000e113, 8'h00, 8'h80, 8'h80, 8'h40, 16'h0011, 2'h1},
        '{32'h00000114, 8'h40, 8'h00, 8'h01, 8'h40, 16'h0011, 2'h1}};

    bbse_core u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    always #2 clk = ~clk;

    // ********
    // Bus tasks
    // ********
    task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] br);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rr);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    // Busy may outlast the write answer on two-cycle operations
    task automatic idle();
        do
        begin
            rd(OFS_STATUS, s, r);
        end
        while (s[0] !== 1'b0);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic run(input bbse_row_t t);
        wr(OFS_FLAGS, 32'(t.f), r);
        wr(OFS_PC, 32'h00000010, r);
        wr(10'h084, 32'(t.s), r);
        wr(OFS_CMD, t.c, r);
        chk("cmd bresp", 32'(RESP_OKAY), 32'(r));
        idle();
        chk("cycles", 32'(t.y), 32'(s[3:2]));
        chk("taken", 32'(t.y == 2'h2), 32'(s[1]));
        rd(10'h084, d, r);
        chk("result", 32'(t.r), d);
        rd(OFS_FLAGS, d, r);
        chk("flags", 32'(t.e), d);
        rd(OFS_PC, d, r);
        chk("pc", 32'(t.p), d);
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ********
    // Sequence
    // ********
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_PC, d, r);
        chk("pc reset", 32'(PC_RST), d);
        foreach (rows[i]) run(rows[i]);
        rd(10'h020, d, r);
        chk("unmapped", 32'(RESP_SLVERR), 32'(r));
        wr(OFS_STATUS, 32'h0000000f, r);
        chk("status wr", 32'(RESP_SLVERR), 32'(r));
        wr(OFS_CMD, 32'h00070115, r);
        idle();
        rd(OFS_FLAGS, d, r);
        chk("flag set", 32'h000000c0, d);
        wr(OFS_CMD, 32'h00060116, r);
        idle();
        rd(OFS_FLAGS, d, r);
        chk("flag clr", 32'h00000080, d);
        wr(OFS_FLAGS, 32'h0000005a, r);
        wr(10'h114, 32'h00000081, r);
        wr(OFS_CMD, 32'h0005600c, r);
        idle();
        chk("io cycles", 32'h00000002, 32'(s[3:2]));
        rd(10'h114, d, r);
        chk("io set", 32'h00000089, d);
        rd(OFS_FLAGS, d, r);
        chk("io flags", 32'h0000005a, d);
        wr(OFS_CMD, 32'h0005600d, r);
        idle();
        chk("io clr cycles", 32'h00000002, 32'(s[3:2]));
        rd(10'h114, d, r);
        chk("io clr", 32'h00000081, d);
        wr(10'h20c, 32'h0000005a, r);
        wr(OFS_XPTR, 32'h00000003, r);
        wr(OFS_CMD, 32'h00000217, r);
        idle();
        rd(10'h088, d, r);
        chk("load", 32'h0000005a, d);
        rd(OFS_XPTR, d, r);
        chk("xptr", 32'h00000004, d);
        give_verdict();
    end

    initial
    begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule // testbench
